// ===== dcwd_map.vh
`ifndef DCWD_MAP_VH
`define DCWD_MAP_VH
`define DCWD_OFS_SRC_END 12'h0000
`define DCWD_OFS_DST_END 12'h0004
`define DCWD_OFS_CTRL 12'h0008
`define DCWD_OFS_STATUS 12'h000C
`define DCWD_OFS_IRQ_STAT 12'h0010
`define DCWD_OFS_IRQ_MASK 12'h0014
`define DCWD_OFS_START 12'h0018
`define DCWD_DST_STEP_HI 31
`define DCWD_DST_STEP_LO 30
`define DCWD_DST_WIDTH_HI 29
`define DCWD_DST_WIDTH_LO 28
`define DCWD_SRC_STEP_HI 27
`define DCWD_SRC_STEP_LO 26
`define DCWD_SRC_WIDTH_HI 25
`define DCWD_SRC_WIDTH_LO 24
`define DCWD_CODE_FIXED 2'h3
`define DCWD_CODE_RESERVED 2'h3
`define DCWD_CTRL_RESET 32'h0000_0000
`define DCWD_PTR_RESET 32'h0000_0000
`define DCWD_IRQ_RESET 2'h0
`define DCWD_IRQ_ILLEGAL 0
`define DCWD_IRQ_STARTED 1
`endif

// ===== dcwd_ctrl_decode.v
// Design decision made here: the address-and-strobe port.
`include "dcwd_map.vh"
`default_nettype none
module dcwd_ctrl_decode
(
	input wire clk,
	input wire arst_n,
	input wire [11:0] addr,
	input wire [31:0] wrData,
	input wire wrStb,
	input wire rdStb,
	output reg [31:0] rdData,
	output reg [2:0] destAddrStep,
	output reg [2:0] srcAddrStep,
	output reg [2:0] destAccessBytes,
	output reg [2:0] srcAccessBytes,
	output reg destFixed,
	output reg srcFixed,
	output reg [31:0] destEndPointer,
	output reg [31:0] srcEndPointer,
	output reg illegalCfg,
	output reg channelStart,
	output reg irq
);
	reg [31:0] channelControlWord;
	reg [1:0] irqStat;
	reg [1:0] irqMask;
	wire [1:0] destStepCode = channelControlWord[`DCWD_DST_STEP_HI:`DCWD_DST_STEP_LO];
	wire [1:0] destWidthCode = channelControlWord[`DCWD_DST_WIDTH_HI:`DCWD_DST_WIDTH_LO];
	wire [1:0] srcStepCode = channelControlWord[`DCWD_SRC_STEP_HI:`DCWD_SRC_STEP_LO];
	wire [1:0] srcWidthCode = channelControlWord[`DCWD_SRC_WIDTH_HI:`DCWD_SRC_WIDTH_LO];
	reg next_illegal;
	reg [1:0] next_irqStat;
	reg [1:0] next_irqMask;
	wire startReq = wrStb && (addr == `DCWD_OFS_START) && wrData[0];

	// code to byte count; fixed and reserved give zero
	function [2:0] codeBytes;
		input [1:0] code;
		begin
			case (code)
				2'h0: codeBytes = 3'h1;
				2'h1: codeBytes = 3'h2;
				2'h2: codeBytes = 3'h4;
				default: codeBytes = 3'h0;
			endcase
		end
	endfunction

	// step shorter than one item; a fixed address is never too short
	function stepTooShort;
		input [1:0] stepCode;
		input [1:0] widthCode;
		begin
			if (stepCode == `DCWD_CODE_FIXED)
				stepTooShort = 1'b0;
			else
				stepTooShort = (stepCode < widthCode);
		end
	endfunction

	// step code that pins the address to its end pointer
	function isFixed;
		input [1:0] stepCode;
		begin
			isFixed = (stepCode == `DCWD_CODE_FIXED);
		end
	endfunction

	// illegal combination check
	always @*
	begin
		next_illegal = 1'b0;
		if (destWidthCode == `DCWD_CODE_RESERVED)
			next_illegal = 1'b1;
		if (srcWidthCode == `DCWD_CODE_RESERVED)
			next_illegal = 1'b1;
		if (destWidthCode != srcWidthCode)
			next_illegal = 1'b1;
		if (stepTooShort(destStepCode, destWidthCode))
			next_illegal = 1'b1;
		if (stepTooShort(srcStepCode, srcWidthCode))
			next_illegal = 1'b1;
	end

	// sticky events, set wins over clear
	always @*
	begin
		next_irqStat = irqStat;
		if (wrStb && addr == `DCWD_OFS_IRQ_STAT)
			next_irqStat = irqStat & ~wrData[1:0];
		if (startReq && next_illegal)
			next_irqStat[`DCWD_IRQ_ILLEGAL] = 1'b1;
		if (startReq && !next_illegal)
			next_irqStat[`DCWD_IRQ_STARTED] = 1'b1;
	end

	// mask next value, so the interrupt sees a new mask at once
	always @*
	begin
		next_irqMask = irqMask;
		if (wrStb && addr == `DCWD_OFS_IRQ_MASK)
			next_irqMask = wrData[1:0];
	end

	// control word, kept whole so reserved bits read back
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			channelControlWord <= `DCWD_CTRL_RESET;
		else if (wrStb && addr == `DCWD_OFS_CTRL)
			channelControlWord <= wrData;
	end

	// source end pointer, inclusive last address
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			srcEndPointer <= `DCWD_PTR_RESET;
		else if (wrStb && addr == `DCWD_OFS_SRC_END)
			srcEndPointer <= wrData;
	end

	// destination end pointer, last address or fixed target
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			destEndPointer <= `DCWD_PTR_RESET;
		else if (wrStb && addr == `DCWD_OFS_DST_END)
			destEndPointer <= wrData;
	end

	// interrupt status and mask registers
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqStat <= `DCWD_IRQ_RESET;
			irqMask <= `DCWD_IRQ_RESET;
		end
		else
		begin
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
		end
	end

	// address step per item
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			destAddrStep <= 3'h0;
			srcAddrStep <= 3'h0;
		end
		else
		begin
			destAddrStep <= codeBytes(destStepCode);
			srcAddrStep <= codeBytes(srcStepCode);
		end
	end

	// access width per item
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			destAccessBytes <= 3'h0;
			srcAccessBytes <= 3'h0;
		end
		else
		begin
			destAccessBytes <= codeBytes(destWidthCode);
			srcAccessBytes <= codeBytes(srcWidthCode);
		end
	end

	// fixed address flags, address held at the end pointer
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			destFixed <= 1'b0;
			srcFixed <= 1'b0;
		end
		else
		begin
			destFixed <= isFixed(destStepCode);
			srcFixed <= isFixed(srcStepCode);
		end
	end

	// legality flag and start gating
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			illegalCfg <= 1'b0;
			channelStart <= 1'b0;
		end
		else
		begin
			illegalCfg <= next_illegal;
			channelStart <= startReq && !next_illegal;
		end
	end

	// level interrupt from unmasked sticky bits
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(next_irqStat & next_irqMask);
	end

	// read port, data one cycle after strobe
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdData <= 32'h0000_0000;
		else if (rdStb)
		begin
			case (addr)
				`DCWD_OFS_CTRL: rdData <= channelControlWord;
				`DCWD_OFS_SRC_END: rdData <= srcEndPointer;
				`DCWD_OFS_DST_END: rdData <= destEndPointer;
				`DCWD_OFS_STATUS: rdData <= {31'h0000_0000, next_illegal};
				`DCWD_OFS_IRQ_STAT: rdData <= {30'h0000_0000, irqStat};
				`DCWD_OFS_IRQ_MASK: rdData <= {30'h0000_0000, irqMask};
				default: rdData <= 32'h0000_0000;
			endcase
		end
		else
			rdData <= 32'h0000_0000;
	end
endmodule
`default_nettype wire

// ===== dcwd_ctl_table.sv
`default_nettype none
module dcwd_ctl_table (
	input wire clk,
	input wire we,
	input wire [1:0] idx,
	input wire [31:0] wd,
	output logic [31:0] word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [4];
	// whole words kept, reserved bits untouched
	always @(posedge clk) if (we) mem[idx] <= wd;
	assign word = mem[idx];
endmodule
`default_nettype wire

// ===== dcwd_ctrl_decode_sva.sv
`default_nettype none
module dcwd_ctrl_decode_sva (
	input wire clk,
	input wire arst_n,
	input wire [11:0] addr,
	input wire [31:0] wrData,
	input wire wrStb,
	input wire [2:0] destAddrStep,
	input wire [2:0] srcAddrStep,
	input wire [2:0] destAccessBytes,
	input wire [2:0] srcAccessBytes,
	input wire destFixed,
	input wire srcFixed,
	input wire [31:0] srcEndPointer,
	input wire [31:0] destEndPointer,
	input wire illegalCfg,
	input wire channelStart
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] d;
	logic [31:0] d2;
	wire wc = wrStb && addr == 12'h008;
	// write data one and two cycles back
	always @(posedge clk)
	begin
		d <= wrData;
		d2 <= d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	dst_step_a: assert property (wc |-> ##2
		destAddrStep == (d2[31:30] == 2'h3 ? 3'h0 : 3'h1 << d2[31:30])) else $error("dst step");
	src_step_a: assert property (wc |-> ##2
		srcAddrStep == (d2[27:26] == 2'h3 ? 3'h0 : 3'h1 << d2[27:26])) else $error("src step");
	dst_width_a: assert property (wc |-> ##2
		destAccessBytes == (d2[29:28] == 2'h3 ? 3'h0 : 3'h1 << d2[29:28]))
		else $error("dst width");
	src_width_a: assert property (wc |-> ##2
		srcAccessBytes == (d2[25:24] == 2'h3 ? 3'h0 : 3'h1 << d2[25:24]))
		else $error("src width");
	fixed_pair_a: assert property (wc |-> ##2
		{destFixed, srcFixed} == {d2[31:30] == 2'h3, d2[27:26] == 2'h3}) else $error("fixed");
	width_mix_a: assert property (wc && wrData[29:28] != wrData[25:24] |-> ##2 illegalCfg)
		else $error("width mix");
	start_legal_a: assert property (channelStart |->
		$past(wrStb) && $past(addr) == 12'h018 && $past(wrData[0]) && !illegalCfg)
		else $error("start");
	src_ptr_a: assert property (wrStb && addr == 12'h000 |=> srcEndPointer == d)
		else $error("src ptr");
	dst_ptr_a: assert property (wrStb && addr == 12'h004 |=> destEndPointer == d)
		else $error("dst ptr");
endmodule
bind dcwd_ctrl_decode dcwd_ctrl_decode_sva sva (.clk, .arst_n, .addr, .wrData, .wrStb,
	.destAddrStep, .srcAddrStep, .destAccessBytes, .srcAccessBytes, .destFixed, .srcFixed,
	.srcEndPointer, .destEndPointer, .illegalCfg, .channelStart);
`default_nettype wire

// ===== dma_channel_ctrl_word_decode_tb_top.sv
`default_nettype none
module dma_channel_ctrl_word_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, arst_n = 0, wrStb = 0, rdStb = 0, tWe = 0;
	logic [1:0] k;
	logic [11:0] addr = 0;
	logic [31:0] wrData = 0, rdData, destEndPointer, srcEndPointer, word, w;
	logic [2:0] destAddrStep, srcAddrStep, destAccessBytes, srcAccessBytes;
	logic destFixed, srcFixed, illegalCfg, channelStart, irq;
	int miscompares = 0, totalChecks = 0, m;
	dcwd_ctrl_decode dut (.clk, .arst_n, .addr, .wrData, .wrStb, .rdStb, .rdData, .destAddrStep,
		.srcAddrStep, .destAccessBytes, .srcAccessBytes, .destFixed, .srcFixed, .destEndPointer,
		.srcEndPointer, .illegalCfg, .channelStart, .irq);
	dcwd_ctl_table tbl (.clk, .we(tWe), .idx(k), .wd(w), .word);
	// one bus cycle, read or write
	task automatic bus(input logic [11:0] a, input logic [31:0] v, input logic rd);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= !rd;
		rdStb <= rd;
		@(posedge clk);
		wrStb <= 0;
		rdStb <= 0;
		tWe <= 0;
		#1;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		totalChecks++;
		if (x !== y) $display("[FAIL] %s expected %h seen %h", n, x, y);
		if (x !== y) miscompares++;
	endtask
	function automatic logic [2:0] pw(input logic [1:0] c);
		return c == 2'h3 ? 3'h0 : 3'h1 << c;
	endfunction
	function automatic logic bad(input logic [31:0] v);
		return v[29:28] == 3 || v[29:28] != v[25:24] || (v[31:30] != 3 && v[31:30] < v[29:28])
			|| (v[27:26] != 3 && v[27:26] < v[25:24]);
	endfunction
	task automatic summarize;
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial forever #2.5 clk = ~clk;
	initial
	begin
		#20000;
		miscompares++;
		summarize();
	end
	// table entry fetched into the control word, then started
	initial
	begin
		void'($urandom(94161));
		repeat (3) @(posedge clk);
		arst_n <= 1;
		for (int i = 0; i < 60; i++)
		begin
			k = 2'(i % 3);
			w = $urandom;
			if (i % 2 == 1) w[31:24] = {2'h3, k, 2'h2, k};
			tWe <= 1;
			bus(12'h000, ~w, 0);
			bus(12'h004, w, 0);
			bus(12'h008, word, 0);
			// decoded outputs settle two edges after the write, checked after the read
			bus(12'h008, 0, 1);
			chk("readback", w, rdData);
			chk("dstep", pw(w[31:30]), destAddrStep);
			chk("sstep", pw(w[27:26]), srcAddrStep);
			chk("dwidth", pw(w[29:28]), destAccessBytes);
			chk("swidth", pw(w[25:24]), srcAccessBytes);
			chk("fixed", {w[31:30] == 3, w[27:26] == 3}, {destFixed, srcFixed});
			chk("sptr", ~w, srcEndPointer);
			chk("dptr", w, destEndPointer);
			chk("illegal", bad(w), illegalCfg);
			bus(12'h00C, 0, 1);
			chk("status", bad(w), rdData);
			m = $urandom % 4;
			bus(12'h014, m, 0);
			bus(12'h018, 1, 0);
			chk("start", !bad(w), channelStart);
			chk("irq", |((bad(w) ? 1 : 2) & m), irq);
			bus(12'h010, 0, 1);
			chk("irqstat", bad(w) ? 1 : 2, rdData);
			bus(12'h010, 3, 0);
			chk("irqclr", 0, irq);
		end
		bus(12'h01C, 0, 1);
		chk("unmapped", 0, rdData);
		summarize();
	end
endmodule
`default_nettype wire
